// >>> hw/fpq_pkg.sv
// Purpose: shared constants and types for the flash protect/query host
// Assumes: 20 MHz controller clock
// Notes:   pin level codes are decoded to real voltages by board logic
`default_nettype none
package fpq_pkg;

  // ==========================================================
  // timing
  localparam int CLK_NS   = 50;                        // clock period
  localparam int T_ACC_NS = 70;                        // read access time
  localparam int T_WP_NS  = 35;                        // write pulse width
  localparam int SYNC_CYC = 2;                         // input synchroniser
  localparam int ACC_CYC  = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int WP_CYC   = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int RD_CYC   = ACC_CYC + SYNC_CYC;        // strobe to capture

  // ==========================================================
  // widths
  localparam int AW = 21;                              // device address pins
  localparam int DW = 16;                              // data pins

  // ==========================================================
  // command codes and addresses
  localparam logic [7:0]    CMD_QUERY  = 8'h98;
  localparam logic [7:0]    CMD_RESET  = 8'hF0;
  localparam logic [AW-1:0] QRY_WADDR  = 21'h000055;   // word width address
  localparam logic [AW:0]   QRY_BADDR  = 22'h0000AA;   // byte width address
  localparam logic [AW-1:0] QRY_AMASK  = 21'h00007F;   // a7 and up forced 0

  // ==========================================================
  // sector group decode
  localparam int          SEL_W      = 9;              // sector_select_bits
  localparam logic [4:0]  GRP_MID    = 5'h08;          // three-sector group
  localparam logic [4:0]  GRP_OUTER  = 5'h02;          // groups below guarded

  // ==========================================================
  // pin level codes
  typedef enum logic [1:0] {
    FPQ_LVL_LOW,
    FPQ_LVL_HIGH,
    FPQ_LVL_HV
  } fpq_level_e;

  // user operations
  typedef enum logic [2:0] {
    FPQ_OP_READ,
    FPQ_OP_WRITE,
    FPQ_OP_QRY_ENTER,
    FPQ_OP_QRY_EXIT,
    FPQ_OP_ACC_ON,
    FPQ_OP_ACC_OFF,
    FPQ_OP_UNP_ON,
    FPQ_OP_UNP_OFF
  } fpq_op_e;

endpackage : fpq_pkg
`default_nettype wire

// >>> hw/fpq_group_dec.sv
// Purpose: decode sector_select_bits into a bottom-boot protection group
// Assumes: input is device address bits 20..12
// Notes:   purely combinational
`timescale 1ns/10ps
`default_nettype none
module fpq_group_dec (
  // sector select
  input  wire logic [fpq_pkg::SEL_W-1:0] sector_select_bits,
  // decode result
  output logic      [4:0]                protection_group,
  output logic                           outer_boot
);

  // ==========================================================
  // group decode
  wire logic [3:0] top4  = sector_select_bits[8:5];
  wire logic [5:0] top6  = sector_select_bits[8:3];
  wire logic       big   = (top4 != 4'h0);
  wire logic       mid   = !big && (top6 != 6'h00);

  // four-sector groups stack upward, then the 3-group, then boot sectors
  assign protection_group = big ? (fpq_pkg::GRP_MID + {1'b0, top4})
                          : mid ? fpq_pkg::GRP_MID
                          : {2'b00, sector_select_bits[2:0]};
  assign outer_boot = (protection_group < fpq_pkg::GRP_OUTER);

endmodule : fpq_group_dec
`default_nettype wire

// >>> hw/fpq_host.sv
// Purpose: host side controller for a parallel boot-sector flash with
//          sector guard, accelerated program, temporary unprotect and
//          query mode
// Assumes: one 20 MHz clock, pins level-shifted by board logic
// Notes:   one bus cycle at a time; strobes and data registered
`timescale 1ns/10ps
`default_nettype none
module fpq_host #(
  parameter int AW = fpq_pkg::AW,
  parameter int DW = fpq_pkg::DW
) (
  // clock and reset
  input  wire logic                 clock,
  input  wire logic                 arst_n,
  input  wire logic                 clk_en,
  // user configuration
  input  wire logic                 word_mode,
  input  wire logic                 guard_hold,
  // user command
  input  wire logic                 cmd_valid,
  output logic                      cmd_ready,
  input  wire fpq_pkg::fpq_op_e     cmd_op,
  input  wire logic [AW:0]          cmd_addr,
  input  wire logic [DW-1:0]        cmd_wdata,
  // user response
  output logic                      rsp_valid,
  output logic [DW-1:0]             rsp_rdata,
  output logic                      rsp_err,
  // mode status
  output logic                      query_active,
  output logic                      accel_active,
  output logic                      unprot_active,
  // flash strobes and address
  output logic                      flash_ce_n,
  output logic                      flash_we_n,
  output logic                      flash_oe_n,
  output logic                      flash_byte_n,
  output logic [AW-1:0]             flash_addr,
  // flash data pins
  input  wire logic [DW-1:0]        flash_dq_i,
  output logic [DW-1:0]             flash_dq_o,
  output logic [DW-1:0]             flash_dq_oe_n,
  // flash level pins
  output fpq_pkg::fpq_level_e       guard_level,
  output fpq_pkg::fpq_level_e       reset_level
);

  typedef enum logic [2:0] {
    FPQ_ST_IDLE,
    FPQ_ST_SETUP,
    FPQ_ST_PULSE,
    FPQ_ST_RECOV,
    FPQ_ST_DONE
  } fpq_state_e;

  // split a user address into pin address and byte lsb
  function automatic logic [AW:0] pin_addr(input logic [AW:0] a,
                                           input logic        wmode);
    pin_addr = wmode ? {1'b0, a[AW-1:0]} : {a[0], a[AW:1]};
  endfunction : pin_addr

  // ==========================================================
  // state
  fpq_state_e          state_q, state_d;
  logic [2:0]          cnt_q;
  logic                is_wr_q;
  logic                word_q;
  logic                query_q, accel_q, unprot_q;
  logic                err_q;
  logic [AW-1:0]       addr_q;
  logic                am1_q;
  logic [DW-1:0]       wdata_q;
  logic [DW-1:0]       rdata_q;
  logic                ce_n_q, we_n_q, oe_n_q;
  logic                drive_q;
  logic [DW-1:0]       dq_s1_q, dq_s2_q;

  // ==========================================================
  // request decode
  wire logic           take     = cmd_valid && cmd_ready && clk_en;
  wire logic [AW:0]    raw_pin  = pin_addr(cmd_addr, word_mode);
  wire logic [AW:0]    qry_raw  = word_mode ? {1'b0, fpq_pkg::QRY_WADDR}
                                            : fpq_pkg::QRY_BADDR;
  wire logic [AW:0]    qry_pin  = pin_addr(qry_raw, word_mode);
  wire logic [AW-1:0]  qry_mask = raw_pin[AW-1:0] & fpq_pkg::QRY_AMASK;
  wire logic [AW-1:0]  rd_addr  = (query_q && word_mode) ? qry_mask
                                                         : raw_pin[AW-1:0];
  wire logic [4:0]     grp;
  wire logic           outer;
  wire logic           guard_lock = guard_hold && !accel_q && outer;
  // program to outer boot sectors with guard low is pointless, even in
  // temporary unprotect, so refuse it before it reaches the pins
  wire logic           wr_refuse  = (cmd_op == fpq_pkg::FPQ_OP_WRITE)
                                    && guard_lock;
  // boost only from plain read mode
  wire logic           acc_refuse = (cmd_op == fpq_pkg::FPQ_OP_ACC_ON)
                                    && (query_q || unprot_q);
  // boost may damage the part on any bus cycle but a program
  wire logic           hv_refuse  = accel_q
                                    && ((cmd_op == fpq_pkg::FPQ_OP_READ)
                                    || (cmd_op == fpq_pkg::FPQ_OP_QRY_ENTER)
                                    || (cmd_op == fpq_pkg::FPQ_OP_QRY_EXIT));
  wire logic           refuse     = wr_refuse || acc_refuse || hv_refuse;
  wire logic           bus_op     = (cmd_op == fpq_pkg::FPQ_OP_READ)
                                    || (cmd_op == fpq_pkg::FPQ_OP_WRITE)
                                    || (cmd_op == fpq_pkg::FPQ_OP_QRY_ENTER)
                                    || (cmd_op == fpq_pkg::FPQ_OP_QRY_EXIT);

  fpq_group_dec u_dec (
    .sector_select_bits (raw_pin[AW-1:AW-fpq_pkg::SEL_W]),
    .protection_group   (grp),
    .outer_boot         (outer)
  );

  // ==========================================================
  // handshake and outputs
  assign cmd_ready     = (state_q == FPQ_ST_IDLE);
  assign rsp_valid     = (state_q == FPQ_ST_DONE);
  assign rsp_rdata     = rdata_q;
  assign rsp_err       = err_q;
  assign query_active  = query_q;
  assign accel_active  = accel_q;
  assign unprot_active = unprot_q;
  assign flash_ce_n    = ce_n_q;
  assign flash_we_n    = we_n_q;
  assign flash_oe_n    = oe_n_q;
  assign flash_byte_n  = word_q;
  assign flash_addr    = addr_q;
  // byte width: dq15 carries the lsb address, dq8..14 float
  assign flash_dq_o    = word_q ? wdata_q : {am1_q, wdata_q[DW-2:0]};
  assign flash_dq_oe_n = word_q ? {DW{!drive_q}}
                                : {1'b0, {(DW-9){1'b1}}, {8{!drive_q}}};
  // pin never left open; boost while accelerating
  assign guard_level   = accel_q    ? fpq_pkg::FPQ_LVL_HV
                       : guard_hold ? fpq_pkg::FPQ_LVL_LOW
                       : fpq_pkg::FPQ_LVL_HIGH;
  assign reset_level   = unprot_q   ? fpq_pkg::FPQ_LVL_HV
                       : fpq_pkg::FPQ_LVL_HIGH;

  // ==========================================================
  // sequencer next state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      FPQ_ST_IDLE:  if (take) state_d = (bus_op && !refuse) ? FPQ_ST_SETUP
                                                            : FPQ_ST_DONE;
      FPQ_ST_SETUP: state_d = FPQ_ST_PULSE;
      FPQ_ST_PULSE: if (cnt_q == 3'd1) state_d = FPQ_ST_RECOV;
      FPQ_ST_RECOV: state_d = FPQ_ST_DONE;
      FPQ_ST_DONE:  state_d = FPQ_ST_IDLE;
      default:      state_d = FPQ_ST_IDLE;  // unused codes recover
    endcase
  end

  // ==========================================================
  // input synchroniser for data pins
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      dq_s1_q <= '0;
      dq_s2_q <= '0;
    end else if (clk_en) begin
      dq_s1_q <= flash_dq_i;
      dq_s2_q <= dq_s1_q;
    end
  end

  // ==========================================================
  // mode flags, updated as a command is taken
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      query_q  <= 1'b0;
      accel_q  <= 1'b0;
      unprot_q <= 1'b0;
      word_q   <= 1'b1;
      err_q    <= 1'b0;
    end else if (take) begin
      word_q <= word_mode;
      err_q  <= refuse;
      if (!refuse) begin
        unique case (cmd_op)
          fpq_pkg::FPQ_OP_QRY_ENTER: query_q  <= 1'b1;
          fpq_pkg::FPQ_OP_QRY_EXIT:  query_q  <= 1'b0;
          fpq_pkg::FPQ_OP_ACC_ON:    accel_q  <= 1'b1;
          fpq_pkg::FPQ_OP_ACC_OFF:   accel_q  <= 1'b0;
          fpq_pkg::FPQ_OP_UNP_ON:    unprot_q <= 1'b1;
          fpq_pkg::FPQ_OP_UNP_OFF:   unprot_q <= 1'b0;
          default: ;
        endcase
      end
    end
  end

  // ==========================================================
  // bus cycle address and data load
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      is_wr_q <= 1'b0;
      addr_q  <= '0;
      am1_q   <= 1'b0;
      wdata_q <= '0;
    end else if (take && bus_op && !refuse) begin
      is_wr_q <= (cmd_op != fpq_pkg::FPQ_OP_READ);
      unique case (cmd_op)
        fpq_pkg::FPQ_OP_QRY_ENTER: begin
          addr_q  <= qry_pin[AW-1:0];
          am1_q   <= qry_pin[AW];
          wdata_q <= {8'h00, fpq_pkg::CMD_QUERY};
        end
        fpq_pkg::FPQ_OP_QRY_EXIT: begin
          addr_q  <= '0;
          am1_q   <= 1'b0;
          wdata_q <= {8'h00, fpq_pkg::CMD_RESET};
        end
        default: begin
          addr_q  <= rd_addr;
          am1_q   <= raw_pin[AW];
          wdata_q <= cmd_wdata;
        end
      endcase
    end
  end

  // ==========================================================
  // strobes, counter and read capture
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= FPQ_ST_IDLE;
      cnt_q   <= '0;
      ce_n_q  <= 1'b1;
      we_n_q  <= 1'b1;
      oe_n_q  <= 1'b1;
      drive_q <= 1'b0;
      rdata_q <= '0;
    end else if (clk_en) begin
      state_q <= state_d;
      unique case (state_q)
        FPQ_ST_SETUP: begin
          ce_n_q  <= 1'b0;
          we_n_q  <= !is_wr_q;
          oe_n_q  <= is_wr_q;
          drive_q <= is_wr_q;
          cnt_q   <= is_wr_q ? 3'(fpq_pkg::WP_CYC) : 3'(fpq_pkg::RD_CYC);
        end
        FPQ_ST_PULSE: begin
          cnt_q <= cnt_q - 3'd1;
          if (cnt_q == 3'd1) begin
            we_n_q <= 1'b1;
            oe_n_q <= 1'b1;
            if (!is_wr_q) rdata_q <= dq_s2_q;
          end
        end
        FPQ_ST_RECOV: begin
          ce_n_q  <= 1'b1;
          drive_q <= 1'b0;
        end
        default: ;
      endcase
    end
  end

endmodule : fpq_host
`default_nettype wire

// >>> testbench/fpq_flash_model.sv
// Purpose: behavioural bottom-boot flash device for the host bench
// Assumes: word-width programs, stored boot protection clear
// Notes:   released data lines show a flipping pattern
`timescale 1ns/10ps
`default_nettype none
module fpq_fm_model (
  // strobes, address and host data
  input  wire logic                ce_n,
  input  wire logic                we_n,
  input  wire logic                oe_n,
  input  wire logic                byte_n,
  input  wire logic [20:0]         addr,
  input  wire logic [15:0]         hd,
  // level pins
  input  wire fpq_pkg::fpq_level_e guard,
  input  wire fpq_pkg::fpq_level_e rst_lvl,
  // read data
  output logic      [15:0]         dq
);
  // ==================================================
  // array, query flag and outer boot lock
  logic [15:0] mem [int];
  logic [15:0] rd;
  logic        qry = 1'b0;
  logic        lock;
  // stored lock is clear, so only a low guard pin locks groups 0 and 1
  assign lock = addr[20:15] == 6'h00 && addr[14:12] < 3'h2
    && guard == fpq_pkg::FPQ_LVL_LOW;
  // query table words 10h to 15h
  function automatic logic [7:0] cfi(input logic [7:0] a);
    case (a)
      8'h10: return 8'h51;
      8'h11: return 8'h52;
      8'h12: return 8'h59;
      8'h13: return 8'h02;
      8'h15: return 8'h40;
      default: return 8'h00;
    endcase
  endfunction : cfi
  // commands and programs act on the rising write strobe
  always @(posedge we_n) begin
    if (!ce_n && hd[7:0] == 8'h98 && (byte_n ? addr == 21'h000055
        : {addr, hd[15]} == 22'h0000AA))
      qry = 1'b1;
    else if (!ce_n && hd[7:0] == 8'hF0)
      qry = 1'b0;
    else if (!ce_n && byte_n && !qry && !lock)
      mem[addr] = hd;
  end
  // read data during a read, a flipping pattern otherwise
  initial dq = 16'hA55A;
  always @(ce_n, oe_n, addr, byte_n, qry, rst_lvl) begin
    if (!ce_n && !oe_n) begin
      rd = mem.exists(addr) ? mem[addr] : 16'hFFFF;
      if (qry)
        rd = {8'h00, cfi(addr[7:0])};
      dq = byte_n ? rd : {~dq[15:8], rd[7:0]};
    end else begin
      dq = ~dq;
    end
  end
endmodule : fpq_fm_model
`default_nettype wire

// >>> testbench/fpq_host_asserts.sv
// Purpose: port checks for the flash protect/query host
// Assumes: one clock, asynchronous active-low reset
// Notes:   bound to every fpq_host instance
`timescale 1ns/10ps
`default_nettype none
module fpq_host_asserts #(
  parameter int AW = fpq_pkg::AW,
  parameter int DW = fpq_pkg::DW
) (
  // clock and reset
  input wire logic                clock,
  input wire logic                arst_n,
  // user side
  input wire logic                word_mode,
  input wire logic                guard_hold,
  input wire logic                cmd_valid,
  input wire logic                cmd_ready,
  input wire fpq_pkg::fpq_op_e    cmd_op,
  input wire logic [AW:0]         cmd_addr,
  input wire logic                rsp_valid,
  input wire logic                rsp_err,
  input wire logic                query_active,
  input wire logic                accel_active,
  // flash pins
  input wire logic                flash_ce_n,
  input wire logic                flash_we_n,
  input wire logic                flash_oe_n,
  input wire logic                flash_byte_n,
  input wire logic [AW-1:0]       flash_addr,
  input wire logic [DW-1:0]       flash_dq_o,
  input wire logic [DW-1:0]       flash_dq_oe_n,
  input wire fpq_pkg::fpq_level_e guard_level
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);
  // ==================================================
  // guard pin levels
  property p_guard_ok;
    guard_level != fpq_pkg::fpq_level_e'(2'h3);
  endproperty
  a_guard_ok: assert property (p_guard_ok)
    else $error("guard pin level code out of range");
  property p_guard_low;
    $rose(guard_hold) && !accel_active
      |-> ##[0:2] guard_level == fpq_pkg::FPQ_LVL_LOW;
  endproperty
  a_guard_low: assert property (p_guard_low)
    else $error("guard pin not lowered on request");
  property p_boost;
    $rose(guard_level == fpq_pkg::FPQ_LVL_HV)
      |-> flash_ce_n && !query_active;
  endproperty
  a_boost: assert property (p_boost)
    else $error("boost level raised outside read mode");
  property p_boost_rd;
    accel_active |-> flash_oe_n;
  endproperty
  a_boost_rd: assert property (p_boost_rd)
    else $error("read strobe used at boost level");
  // query entry, exit and read bus cycles
  property p_qry_on;
    $rose(query_active) |-> ##[1:4] !flash_we_n
      && flash_addr[7:0] == 8'h55 && flash_dq_o[7:0] == 8'h98;
  endproperty
  a_qry_on: assert property (p_qry_on)
    else $error("query entry write missing");
  property p_qry_off;
    $fell(query_active) |-> ##[1:4] !flash_we_n
      && flash_dq_o[7:0] == 8'hF0;
  endproperty
  a_qry_off: assert property (p_qry_off)
    else $error("reset command write missing");
  property p_amask;
    query_active && flash_byte_n && !flash_oe_n
      |-> flash_addr[AW-1:7] == '0;
  endproperty
  a_amask: assert property (p_amask)
    else $error("upper address bits set in query read");
  // data pin ownership
  property p_byte_pins;
    !flash_byte_n |-> flash_dq_oe_n[14:8] == 7'h7F && !flash_dq_oe_n[15];
  endproperty
  a_byte_pins: assert property (p_byte_pins)
    else $error("byte width data pin enables wrong");
  property p_rd_free;
    !flash_oe_n |-> flash_dq_oe_n[7:0] == 8'hFF;
  endproperty
  a_rd_free: assert property (p_rd_free)
    else $error("host drives data during read");
  // guarded boot sector write is refused without a bus cycle
  property p_refuse;
    cmd_valid && cmd_ready && word_mode && guard_hold && !accel_active
      && cmd_op == fpq_pkg::FPQ_OP_WRITE && cmd_addr[20:15] == 6'h00
      && cmd_addr[14:12] < 3'h2 |=> rsp_valid && rsp_err && flash_we_n;
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("guarded boot write not refused");
  c_qry: cover property ($rose(query_active));
  c_acc: cover property ($rose(accel_active));
  c_err: cover property (rsp_valid && rsp_err);
endmodule : fpq_host_asserts
bind fpq_host fpq_host_asserts #(.AW(AW), .DW(DW)) i_chk (
  .clock, .arst_n, .word_mode, .guard_hold, .cmd_valid, .cmd_ready,
  .cmd_op, .cmd_addr, .rsp_valid, .rsp_err, .query_active,
  .accel_active, .flash_ce_n, .flash_we_n, .flash_oe_n, .flash_byte_n,
  .flash_addr, .flash_dq_o, .flash_dq_oe_n, .guard_level
);
`default_nettype wire

// >>> testbench/tb_flash_protect_and_cfi_query.sv
// Purpose: self-checking bench for the flash protect/query host
// Assumes: array accesses in word width only
// Notes:   a bench state model gives every expected value
`timescale 1ns/10ps
`default_nettype none
module tb_flash_protect_and_cfi_query;
  // ==================================================
  // stimulus, observed pins and bench state
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic clk_en = 1'b1;
  logic word_mode = 1'b1;
  logic guard_hold = 1'b1;
  logic cmd_valid = 1'b0;
  logic [21:0] cmd_addr = '0;
  logic [15:0] cmd_wdata = '0;
  fpq_pkg::fpq_op_e cmd_op = fpq_pkg::FPQ_OP_READ;
  logic cmd_ready, rsp_valid, rsp_err, query_active, accel_active;
  logic unprot_active, flash_ce_n, flash_we_n, flash_oe_n, flash_byte_n;
  logic [20:0] flash_addr;
  logic [15:0] rsp_rdata, flash_dq_o, flash_dq_oe_n, flash_dq_i, mdl_dq;
  fpq_pkg::fpq_level_e guard_level, reset_level;
  int num_errors = 0, n_checks = 0, seed = 54, i, k;
  logic e_qry = 1'b0, e_acc = 1'b0, e_unp = 1'b0;
  logic [15:0] e_mem [int];
  logic [21:0] ga [5] = '{22'h000100, 22'h001000, 22'h002000,
                          22'h008000, 22'h1F0000};
  logic [7:0] qt [6] = '{8'h51, 8'h52, 8'h59, 8'h02, 8'h00, 8'h40};
  always #25 clock = ~clock;
  // wire level: host enables win, else the device
  assign flash_dq_i = (flash_dq_o & ~flash_dq_oe_n) | (mdl_dq & flash_dq_oe_n);
  fpq_host i_dut (
    .clock, .arst_n, .clk_en, .word_mode, .guard_hold, .cmd_valid,
    .cmd_ready, .cmd_op, .cmd_addr, .cmd_wdata, .rsp_valid, .rsp_rdata,
    .rsp_err, .query_active, .accel_active, .unprot_active, .flash_ce_n,
    .flash_we_n, .flash_oe_n, .flash_byte_n, .flash_addr, .flash_dq_i,
    .flash_dq_o, .flash_dq_oe_n, .guard_level, .reset_level
  );
  fpq_fm_model i_flash (
    .ce_n(flash_ce_n), .we_n(flash_we_n), .oe_n(flash_oe_n),
    .byte_n(flash_byte_n), .addr(flash_addr), .hd(flash_dq_o),
    .guard(guard_level), .rst_lvl(reset_level), .dq(mdl_dq)
  );
  // compare one value and count it
  task automatic chk(input string nm, input logic [15:0] s, e);
    n_checks++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // one command through the handshake, then all results compared
  task automatic run(input fpq_pkg::fpq_op_e op, input logic [21:0] a);
    logic [15:0] d, m, xd;
    logic        xe;
    int          n, x;
    d = 16'($random(seed)) & 16'hFF7F;
    x = word_mode ? int'(a[6:0]) : int'(a[8:1]);
    m = word_mode ? 16'hFFFF : 16'h00FF;
    xd = e_mem.exists(a) ? e_mem[a] : 16'hFFFF;
    if (e_qry)
      xd = (x > 15 && x < 22) ? {8'h00, qt[x-16]} : 16'h0000;
    xe = (op == fpq_pkg::FPQ_OP_WRITE && guard_hold && !e_acc
      && a[20:15] == 6'h00 && a[14:12] < 3'h2)
      || (op == fpq_pkg::FPQ_OP_ACC_ON && (e_qry || e_unp))
      || (e_acc && (op == fpq_pkg::FPQ_OP_READ
      || op == fpq_pkg::FPQ_OP_QRY_ENTER || op == fpq_pkg::FPQ_OP_QRY_EXIT));
    cmd_op = op;
    cmd_addr = a;
    cmd_wdata = d;
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1) @(negedge clock);
    @(negedge clock);
    cmd_valid = 1'b0;
    for (n = 0; n < 20 && rsp_valid !== 1'b1; n++) @(negedge clock);
    if (!xe) begin
      case (op)
        fpq_pkg::FPQ_OP_QRY_ENTER: e_qry = 1'b1;
        fpq_pkg::FPQ_OP_QRY_EXIT: e_qry = 1'b0;
        fpq_pkg::FPQ_OP_ACC_ON: e_acc = 1'b1;
        fpq_pkg::FPQ_OP_ACC_OFF: e_acc = 1'b0;
        fpq_pkg::FPQ_OP_UNP_ON: e_unp = 1'b1;
        fpq_pkg::FPQ_OP_UNP_OFF: e_unp = 1'b0;
        fpq_pkg::FPQ_OP_WRITE: e_mem[a] = d;
        default: x = 0;
      endcase
    end
    chk("answer", 16'(n < 20), 16'h0001);
    chk("refused", 16'(rsp_err), 16'(xe));
    if (op == fpq_pkg::FPQ_OP_READ && !xe)
      chk("rdata", rsp_rdata & m, xd & m);
    chk("query", 16'(query_active), 16'(e_qry));
    chk("accel", 16'(accel_active), 16'(e_acc));
    chk("unprot", 16'(unprot_active), 16'(e_unp));
    chk("guard", 16'(guard_level), e_acc ? 16'(fpq_pkg::FPQ_LVL_HV)
      : 16'(guard_hold ? fpq_pkg::FPQ_LVL_LOW : fpq_pkg::FPQ_LVL_HIGH));
    chk("reset", 16'(reset_level), e_unp ? 16'(fpq_pkg::FPQ_LVL_HV)
      : 16'(fpq_pkg::FPQ_LVL_HIGH));
  endtask : run
  // counts, verdict and end of run
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict
  // watchdog against a hung handshake
  initial begin
    #(50 * 5000);
    num_errors++;
    give_verdict();
  end
  // main sequence
  initial begin
    repeat (5) @(negedge clock);
    arst_n = 1'b1;
    run(fpq_pkg::FPQ_OP_READ, 22'h000040);
    run(fpq_pkg::FPQ_OP_QRY_ENTER, '0);
    for (i = 16; i < 27; i++)
      run(fpq_pkg::FPQ_OP_READ, 22'(i) | (22'h000080 << (i % 8)));
    run(fpq_pkg::FPQ_OP_QRY_EXIT, '0);
    word_mode = 1'b0;
    run(fpq_pkg::FPQ_OP_QRY_ENTER, '0);
    for (i = 32; i < 54; i += 2)
      run(fpq_pkg::FPQ_OP_READ, 22'(i));
    run(fpq_pkg::FPQ_OP_QRY_EXIT, '0);
    word_mode = 1'b1;
    $display("query tests done");
    for (k = 0; k < 2; k++) begin
      guard_hold = (k == 0);
      for (i = 0; i < 5; i++) begin
        run(fpq_pkg::FPQ_OP_WRITE, ga[i] + 22'(k));
        run(fpq_pkg::FPQ_OP_READ, ga[i] + 22'(k));
      end
    end
    guard_hold = 1'b1;
    for (i = 0; i < 8; i++) begin
      k = $random(seed) & 32'h001FFFFF;
      run(fpq_pkg::FPQ_OP_WRITE, 22'(k));
      run(fpq_pkg::FPQ_OP_READ, 22'(k));
    end
    $display("protection tests done");
    run(fpq_pkg::FPQ_OP_ACC_ON, '0);
    run(fpq_pkg::FPQ_OP_QRY_ENTER, '0);
    run(fpq_pkg::FPQ_OP_WRITE, 22'h000300);
    run(fpq_pkg::FPQ_OP_READ, 22'h000300);
    run(fpq_pkg::FPQ_OP_ACC_OFF, '0);
    run(fpq_pkg::FPQ_OP_READ, 22'h000300);
    run(fpq_pkg::FPQ_OP_QRY_ENTER, '0);
    run(fpq_pkg::FPQ_OP_ACC_ON, '0);
    run(fpq_pkg::FPQ_OP_QRY_EXIT, '0);
    run(fpq_pkg::FPQ_OP_UNP_ON, '0);
    run(fpq_pkg::FPQ_OP_ACC_ON, '0);
    run(fpq_pkg::FPQ_OP_WRITE, 22'h001300);
    run(fpq_pkg::FPQ_OP_WRITE, 22'h004400);
    run(fpq_pkg::FPQ_OP_READ, 22'h004400);
    run(fpq_pkg::FPQ_OP_UNP_OFF, '0);
    $display("mode tests done");
    give_verdict();
  end
endmodule : tb_flash_protect_and_cfi_query
`default_nettype wire
